/* File: design/tdm_pkg.sv */
package tdm_pkg;
    // Frame and data shape
    localparam int NCH = 4;
    localparam int DW = 16;
    localparam int LANES = 4;
    // Buffer addressing
    localparam int BASE_W = 24;
    localparam int UNIT_W = 21;
    localparam int OFF_W = 28;
    localparam int ADDR_W = 29;
    localparam int THR_W = 25;
    localparam int BYTE_SH = 3;
    localparam int STEP_PLAIN_BYTES = 8;
    localparam int STEP_LAW_BYTES = 16;
    localparam int STEP_PLAIN_SH = $clog2(STEP_PLAIN_BYTES * 8);
    localparam int STEP_LAW_SH = $clog2(STEP_LAW_BYTES * 8);
    localparam int BUF_MAX_BYTES = 16 * 1024 * 1024;
    // Frame sync generator counter
    localparam int GCNT_W = 6;
    localparam int FLEN_W = 7;
    // Link clock limits kept by the partner
    localparam real REF_CLK_MHZ = 100.0;
    localparam real BCLK_MAX_1L_MHZ = 62.5;
    localparam real BCLK_MAX_2L_MHZ = 31.25;
    localparam real BCLK_MAX_4L_MHZ = 15.63;
    // Reset values
    localparam logic [OFF_W-1:0] OFF_RST = 28'h0000000;
    localparam logic [1:0] DLY_ONE = 2'h1;

    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_RUN} phase_t;

    // Bits per channel word from the word size select
    function automatic logic [4:0] word_bits(input logic [1:0] sel);
        return 5'h02 << sel;
    endfunction

    function automatic logic [DW-1:0] word_mask(input logic [1:0] sel);
        return 16'hFFFF >> (5'h10 - word_bits(sel));
    endfunction
endpackage

/* File: design/link_sync.sv */
`timescale 1ns/1ps
module link_sync
    import tdm_pkg::*;
#(
    parameter int N = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Pins, bit 0 is the link clock
    input wire logic [N-1:0] i_async,
    // Synchronised levels and clock edges
    output logic [N-1:0] o_level,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic prev;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s = s;
        next_s.meta = i_async;
        next_s.sync = s.meta;
        next_s.prev = s.sync[0];
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_level = s.sync;
    assign o_rise = s.sync[0] & ~s.prev;
    assign o_fall = ~s.sync[0] & s.prev;
endmodule // link_sync

/* File: design/tdm_serial_port.sv */
// How it works
// (RULE1) Each instance is one self-contained module with its own pins and settings.
// (RULE2) Split mode: receive and transmit use their own clock, sync and line.
// (RULE3) Shared mode: four lines each way, one clock and sync for both.
// (RULE4) Partner keeps bit clock within 62.5, 31.25 or 15.63 MHz by lanes.
// (RULE5) Buffer size counts in 8 byte steps, 16 byte steps with companding.
// (RULE6) All receive buffers written at one common offset from each base.
// (RULE7) All transmit buffers read at one common offset from each base.
// (RULE8) One word size setting covers every channel.
// (RULE9) Two receive and two transmit offset thresholds flag a pulse.
// (RULE10) Inactive channels are neither written nor read.
// (RULE11) Channel words of 2, 4, 8 or 16 bits kept at link width.
// (RULE12) Transmit frame sync pin is either input or driven output.
// (RULE13) Sync and data sampled on the selected clock edge.
// (RULE14) Frame sync polarity is selectable.
// (RULE15) First bit follows frame sync by zero to three bit periods.
// (RULE16) Driven frame sync gives one pulse per frame on transmit clock.
`timescale 1ns/1ps
module tdm_serial_port
    import tdm_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Configuration
    input wire logic i_shared_mode,
    input wire logic i_sample_rise,
    input wire logic i_fs_active_low,
    input wire logic [1:0] i_fs_delay,
    input wire logic [1:0] i_word_sel,
    input wire logic [NCH-1:0] i_ch_active,
    input wire logic i_law_en,
    input wire logic [UNIT_W-1:0] i_buf_units,
    input wire logic i_tx_fs_drive,
    input wire logic [NCH-1:0][BASE_W-1:0] i_rx_base,
    input wire logic [NCH-1:0][BASE_W-1:0] i_tx_base,
    input wire logic [1:0][THR_W-1:0] i_rx_thr,
    input wire logic [1:0][THR_W-1:0] i_tx_thr,
    // Receive link
    input wire logic i_rx_bclk,
    input wire logic i_rx_fs,
    input wire logic [LANES-1:0] i_rx_data,
    // Transmit link
    input wire logic i_tx_bclk,
    input wire logic i_tx_fs,
    output logic o_tx_fs,
    output logic o_tx_fs_oe,
    output logic [LANES-1:0] o_tx_data,
    // Receive buffer write port
    output logic o_rx_wr_en,
    output logic [1:0] o_rx_wr_ch,
    output logic [ADDR_W-1:0] o_rx_wr_bitaddr,
    output logic [DW-1:0] o_rx_wr_data,
    // Transmit buffer read port
    output logic o_tx_rd_en,
    output logic [1:0] o_tx_rd_ch,
    output logic [ADDR_W-1:0] o_tx_rd_bitaddr,
    input wire logic [DW-1:0] i_tx_rd_data,
    // Status
    output logic [OFF_W-1:0] o_rx_off,
    output logic [OFF_W-1:0] o_tx_off,
    output logic [1:0] o_rx_thr_hit,
    output logic [1:0] o_tx_thr_hit
);
    typedef struct packed {
        phase_t ph;
        logic [1:0] dcnt;
        logic [4:0] bits;
        logic [1:0] ch;
        logic fs_prev;
        logic [OFF_W-1:0] off;
    } eng_t;

    typedef struct packed {
        eng_t rx;
        eng_t tx;
        logic [DW-1:0] rsr;
        logic [DW-1:0] tsr;
        logic [DW-1:0] nxt;
        logic [GCNT_W-1:0] gcnt;
        logic rx_wr_en;
        logic [1:0] rx_wr_ch;
        logic [ADDR_W-1:0] rx_wr_addr;
        logic [DW-1:0] rx_wr_data;
        logic rd_en;
        logic [1:0] rd_ch;
        logic [ADDR_W-1:0] rd_addr;
        logic [LANES-1:0] tx_data;
        logic fs_pin;
        logic fs_oe;
        logic [1:0] rx_hit;
        logic [1:0] tx_hit;
    } state_t;

    state_t s;
    state_t n;
    logic [5:0] rx_lv;
    logic [1:0] tx_lv;
    logic rx_rise;
    logic rx_fall;
    logic tx_rise;
    logic tx_fall;
    logic lanes4;
    logic [4:0] w;
    logic [4:0] aw;
    logic [4:0] inc;
    logic [4:0] pps;
    logic [FLEN_W-1:0] flen;
    logic [OFF_W-1:0] lim;
    logic smp_rx;
    logic smp_tx;
    logic drv_tx;
    logic rx_fs;
    logic tx_fs;

    function automatic logic [OFF_W-1:0] adv(input logic [OFF_W-1:0] off,
                                             input logic [4:0] wb,
                                             input logic [OFF_W-1:0] lm);
        logic [OFF_W-1:0] o;
        o = off + OFF_W'(wb);
        return (o >= lm) ? OFF_RST : o;
    endfunction

    function automatic logic [1:0] thr_hit(input logic [OFF_W-1:0] old_off,
                                           input logic [OFF_W-1:0] new_off,
                                           input logic [1:0][THR_W-1:0] thr);
        logic [1:0] h;
        h = 2'h0;
        for (int i = 0; i < 2; i++) begin
            h[i] = (new_off[OFF_W-1:BYTE_SH] == thr[i]) && (old_off[OFF_W-1:BYTE_SH] != thr[i]);
        end
        return h;
    endfunction

    function automatic logic [ADDR_W-1:0] bit_addr(input logic [BASE_W-1:0] base,
                                                   input logic [OFF_W-1:0] off);
        return ADDR_W'({base, 3'h0}) + ADDR_W'(off);
    endfunction

    // (RULE1) own pin synchronisers
    link_sync #(.N(6)) u_rx_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async({i_rx_data, i_rx_fs, i_rx_bclk}),
        .o_level(rx_lv),
        .o_rise(rx_rise),
        .o_fall(rx_fall)
    );

    link_sync #(.N(2)) u_tx_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async({i_tx_fs, i_tx_bclk}),
        .o_level(tx_lv),
        .o_rise(tx_rise),
        .o_fall(tx_fall)
    );

    // (RULE8) (RULE11) one word width
    assign w = word_bits(i_word_sel);
    assign lanes4 = i_shared_mode;
    assign aw = (lanes4 && w < 5'h4) ? 5'h4 : w;
    assign inc = lanes4 ? 5'h4 : 5'h1;
    assign pps = lanes4 ? (aw >> 2) : aw;
    assign flen = FLEN_W'(pps) * FLEN_W'(NCH);
    // (RULE5) buffer size steps
    assign lim = i_law_en ? (OFF_W'(i_buf_units) << STEP_LAW_SH)
                          : (OFF_W'(i_buf_units) << STEP_PLAIN_SH);
    // (RULE13) sample edge select
    assign smp_rx = i_sample_rise ? rx_rise : rx_fall;
    // (RULE2) (RULE3) transmit clock source
    assign smp_tx = i_shared_mode ? smp_rx : (i_sample_rise ? tx_rise : tx_fall);
    assign drv_tx = i_shared_mode ? (i_sample_rise ? rx_fall : rx_rise)
                                  : (i_sample_rise ? tx_fall : tx_rise);
    // (RULE14) sync polarity
    assign rx_fs = rx_lv[1] ^ i_fs_active_low;
    assign tx_fs = i_tx_fs_drive ? (s.fs_pin ^ i_fs_active_low)
                                 : ((i_shared_mode ? rx_lv[1] : tx_lv[1]) ^ i_fs_active_low);

    always_comb begin
        logic [DW-1:0] rsr_n;
        logic [4:0] tb;
        logic [1:0] kn;
        logic rx_take;
        logic tx_load;
        logic tx_rd;
        rsr_n = s.rsr;
        tb = 5'h00;
        kn = 2'h0;
        rx_take = 1'b0;
        tx_load = 1'b0;
        tx_rd = 1'b0;
        n = s;
        n.rx_wr_en = 1'b0;
        n.rd_en = 1'b0;
        n.rx_hit = 2'h0;
        n.tx_hit = 2'h0;
        // (RULE12) sync pin direction
        n.fs_oe = i_tx_fs_drive;
        if (s.rd_en) begin
            n.nxt = i_tx_rd_data;
        end
        // (RULE15) receive frame delay
        if (smp_rx) begin
            n.rx.fs_prev = rx_fs;
            unique case (s.rx.ph)
                PH_IDLE: begin
                    if (rx_fs && !s.rx.fs_prev) begin
                        if (i_fs_delay == 2'h0) begin
                            rx_take = 1'b1;
                        end else begin
                            n.rx.ph = PH_WAIT;
                            n.rx.dcnt = i_fs_delay;
                        end
                    end
                end
                PH_WAIT: begin
                    if (s.rx.dcnt == DLY_ONE) begin
                        rx_take = 1'b1;
                    end else begin
                        n.rx.dcnt = s.rx.dcnt - 2'h1;
                    end
                end
                PH_RUN: rx_take = 1'b1;
            endcase
        end
        if (rx_take) begin
            n.rx.ph = PH_RUN;
            rsr_n = lanes4 ? {s.rsr[DW-5:0], rx_lv[5:2]} : {s.rsr[DW-2:0], rx_lv[2]};
            n.rsr = rsr_n;
            tb = s.rx.bits + inc;
            if (tb >= aw) begin
                n.rx.bits = 5'h00;
                // (RULE10) (RULE6) write active slots
                n.rx_wr_en = i_ch_active[s.rx.ch];
                n.rx_wr_ch = s.rx.ch;
                n.rx_wr_addr = bit_addr(i_rx_base[s.rx.ch], s.rx.off);
                n.rx_wr_data = rsr_n & word_mask(i_word_sel);
                if (s.rx.ch == 2'(NCH - 1)) begin
                    n.rx.ph = PH_IDLE;
                    n.rx.ch = 2'h0;
                    n.rx.off = adv(s.rx.off, w, lim);
                    // (RULE9) receive thresholds
                    n.rx_hit = thr_hit(s.rx.off, n.rx.off, i_rx_thr);
                end else begin
                    n.rx.ch = s.rx.ch + 2'h1;
                end
            end else begin
                n.rx.bits = tb;
            end
        end
        // (RULE16) one sync per frame
        if (drv_tx) begin
            n.gcnt = (FLEN_W'(s.gcnt) == flen - 7'h01) ? 6'h00 : s.gcnt + 6'h01;
            n.fs_pin = (n.gcnt == 6'h00) ^ i_fs_active_low;
        end
        // (RULE15) transmit frame delay
        if (smp_tx) begin
            n.tx.fs_prev = tx_fs;
            unique case (s.tx.ph)
                PH_IDLE: begin
                    if (tx_fs && !s.tx.fs_prev) begin
                        if (i_fs_delay == 2'h0) begin
                            tx_load = 1'b1;
                        end else begin
                            n.tx.ph = PH_WAIT;
                            n.tx.dcnt = i_fs_delay;
                        end
                    end
                end
                PH_WAIT: begin
                    if (s.tx.dcnt == DLY_ONE) begin
                        tx_load = 1'b1;
                    end else begin
                        n.tx.dcnt = s.tx.dcnt - 2'h1;
                    end
                end
                PH_RUN: ;
            endcase
        end
        if (tx_load) begin
            n.tx.ph = PH_RUN;
            n.tx.ch = 2'h0;
            n.tx.bits = 5'h00;
            tx_rd = 1'b1;
        end else if (drv_tx && s.tx.ph == PH_RUN) begin
            n.tx_data = lanes4 ? s.tsr[DW-1:DW-4] : {3'h0, s.tsr[DW-1]};
            n.tsr = lanes4 ? (s.tsr << 4) : (s.tsr << 1);
            tb = s.tx.bits + inc;
            if (tb >= aw) begin
                n.tx.bits = 5'h00;
                if (s.tx.ch == 2'(NCH - 1)) begin
                    n.tx.ph = PH_IDLE;
                    n.tx.ch = 2'h0;
                end else begin
                    n.tx.ch = s.tx.ch + 2'h1;
                    kn = s.tx.ch + 2'h1;
                    tx_rd = 1'b1;
                end
            end else begin
                n.tx.bits = tb;
            end
        end
        if (tx_rd) begin
            // (RULE10) inactive slot sends zero
            n.tsr = i_ch_active[kn] ? (s.nxt << (5'h10 - aw)) : 16'h0000;
            if (kn == 2'(NCH - 1)) begin
                n.tx.off = adv(s.tx.off, w, lim);
                // (RULE9) transmit thresholds
                n.tx_hit = thr_hit(s.tx.off, n.tx.off, i_tx_thr);
            end
            // (RULE7) common read offset
            n.rd_en = i_ch_active[kn + 2'h1];
            n.rd_ch = kn + 2'h1;
            n.rd_addr = bit_addr(i_tx_base[kn + 2'h1], n.tx.off);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_tx_fs = s.fs_pin;
    assign o_tx_fs_oe = s.fs_oe;
    assign o_tx_data = s.tx_data;
    assign o_rx_wr_en = s.rx_wr_en;
    assign o_rx_wr_ch = s.rx_wr_ch;
    assign o_rx_wr_bitaddr = s.rx_wr_addr;
    assign o_rx_wr_data = s.rx_wr_data;
    assign o_tx_rd_en = s.rd_en;
    assign o_tx_rd_ch = s.rd_ch;
    assign o_tx_rd_bitaddr = s.rd_addr;
    assign o_rx_off = s.rx.off;
    assign o_tx_off = s.tx.off;
    assign o_rx_thr_hit = s.rx_hit;
    assign o_tx_thr_hit = s.tx_hit;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_rx_common_off;
        s.rx_wr_en |-> s.rx_wr_addr == bit_addr(i_rx_base[s.rx_wr_ch], $past(s.rx.off));
    endproperty
    a_rx_common_off: assert property (p_rx_common_off) // (RULE6)
        else $error("receive write address off common offset");

    property p_tx_common_off;
        s.rd_en |-> s.rd_addr == bit_addr(i_tx_base[s.rd_ch], s.tx.off);
    endproperty
    a_tx_common_off: assert property (p_tx_common_off) // (RULE7)
        else $error("transmit read address off common offset");

    property p_rx_width;
        s.rx_wr_en |-> (s.rx_wr_data & ~word_mask(i_word_sel)) == 16'h0000;
    endproperty
    a_rx_width: assert property (p_rx_width) // (RULE11)
        else $error("receive word wider than word size");

    property p_rx_active;
        s.rx_wr_en |-> |($past(i_ch_active) & (NCH'(1) << s.rx_wr_ch));
    endproperty
    a_rx_active: assert property (p_rx_active) // (RULE10)
        else $error("inactive channel written");

    property p_rx_edge;
        $changed(s.rx.ph) |-> $past(smp_rx);
    endproperty
    a_rx_edge: assert property (p_rx_edge) // (RULE13)
        else $error("receive phase moved off sample edge");

    property p_rx_delay;
        $changed(s.rx.ph) && s.rx.ph == PH_WAIT |-> s.rx.dcnt == $past(i_fs_delay);
    endproperty
    a_rx_delay: assert property (p_rx_delay) // (RULE15)
        else $error("frame delay not loaded");

    property p_thr;
        (s.rx_hit[0] |-> s.rx.off[OFF_W-1:BYTE_SH] == i_rx_thr[0])
        and (s.tx_hit[1] |-> s.tx.off[OFF_W-1:BYTE_SH] == i_tx_thr[1]);
    endproperty
    a_thr: assert property (p_thr) // (RULE9)
        else $error("threshold pulse without offset match");

    property p_fs_gen;
        s.fs_oe && $rose(s.fs_pin ^ i_fs_active_low) |-> s.gcnt == 6'h00;
    endproperty
    a_fs_gen: assert property (p_fs_gen) // (RULE16)
        else $error("generated sync not at frame count zero");

    property p_shared_clk;
        i_shared_mode && $changed(s.tx_data) |-> $past(i_sample_rise ? rx_fall : rx_rise);
    endproperty
    a_shared_clk: assert property (p_shared_clk) // (RULE3)
        else $error("shared mode data moved off receive clock");

    property p_wrap;
        lim != OFF_RST |-> s.rx.off < lim;
    endproperty
    a_wrap: assert property (p_wrap) // (RULE5)
        else $error("receive offset past buffer size");
endmodule // tdm_serial_port

/* File: dv/link_partner.sv */
`timescale 1ns/1ps
module link_partner
    import tdm_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Link toward the port
    output logic o_bclk,
    output logic o_fs,
    output logic [LANES-1:0] o_data,
    // Transmit buffer read port
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_rd_bitaddr,
    output logic [DW-1:0] o_rd_data
);
    initial begin
        o_bclk = 1'b0;
        o_fs = 1'b0;
        o_data = 4'h0;
    end

    task automatic bit_period(input logic sr, input logic fs_lvl, input logic [3:0] v);
        @(posedge i_ref_clk);
        o_bclk <= ~sr;
        o_fs <= fs_lvl;
        o_data <= v;
        repeat (4) @(posedge i_ref_clk);
        o_bclk <= sr;
        repeat (3) @(posedge i_ref_clk);
    endtask

    // One frame: inactive sync, sync, delay, four slots MSB first
    task automatic send_frame(input logic sr, input logic al, input logic [1:0] dly,
            input logic [1:0] ws, input logic sh, input logic [3:0][15:0] w);
        int wb, np, j, p;
        logic [3:0] v;
        wb = 2 << ws;
        np = sh ? ((wb > 4) ? wb / 4 : 1) : wb;
        v = ~o_data;
        bit_period(sr, al, v);
        for (j = 0; j < dly + 4 * np; j++) begin
            p = j - dly;
            v = ~v;
            if (p >= 0 && !sh) v[0] = w[p / np][wb - 1 - p % np];
            else if (p >= 0 && wb == 2) v[1:0] = w[p / np][1:0];
            else if (p >= 0) v = w[p / np][4 * (np - 1 - p % np) +: 4];
            bit_period(sr, (j == 0) ^ al, v);
        end
        @(posedge i_ref_clk);
        o_bclk <= ~sr;
        o_fs <= al;
        o_data <= ~v;
    endtask

    // Read data stands while the request stands, captured at its closing edge
    assign o_rd_data = i_rd_en ? (i_rd_bitaddr[15:0] ^ 16'hA5C3) : 16'h0000;
endmodule // link_partner

/* File: dv/tdm_serial_port_test.sv */
`timescale 1ns/1ps
module tdm_serial_port_test;
    import tdm_pkg::*;
    logic clk, rst, shared_mode, sample_rise, fs_active_low, law_en, tx_fs_drive;
    logic [1:0] fs_delay, word_sel;
    logic [NCH-1:0] ch_active;
    logic [UNIT_W-1:0] buf_units;
    logic [NCH-1:0][BASE_W-1:0] rx_base, tx_base;
    logic [1:0][THR_W-1:0] rx_thr, tx_thr;
    logic rx_bclk, rx_fs, tx_fs, tx_fs_oe, rx_wr_en, tx_rd_en;
    logic [LANES-1:0] rx_data, tx_data;
    logic [1:0] rx_wr_ch, tx_rd_ch, rx_thr_hit, tx_thr_hit, rx_hits;
    logic [ADDR_W-1:0] rx_wr_bitaddr, tx_rd_bitaddr;
    logic [DW-1:0] rx_wr_data, tx_rd_data;
    logic [OFF_W-1:0] rx_off, tx_off;
    logic [46:0] wr_q[$];
    int miscompares, checked, cycles, fs_act, fs_cycles, tests;

    tdm_serial_port tdm_serial_port_i (
        .i_ref_clk(clk), .i_rst(rst), .i_shared_mode(shared_mode),
        .i_sample_rise(sample_rise), .i_fs_active_low(fs_active_low), .i_fs_delay(fs_delay),
        .i_word_sel(word_sel), .i_ch_active(ch_active), .i_law_en(law_en),
        .i_buf_units(buf_units), .i_tx_fs_drive(tx_fs_drive), .i_rx_base(rx_base),
        .i_tx_base(tx_base), .i_rx_thr(rx_thr), .i_tx_thr(tx_thr), .i_rx_bclk(rx_bclk),
        .i_rx_fs(rx_fs), .i_rx_data(rx_data), .i_tx_bclk(rx_bclk), .i_tx_fs(rx_fs),
        .o_tx_fs(tx_fs), .o_tx_fs_oe(tx_fs_oe), .o_tx_data(tx_data), .o_rx_wr_en(rx_wr_en),
        .o_rx_wr_ch(rx_wr_ch), .o_rx_wr_bitaddr(rx_wr_bitaddr), .o_rx_wr_data(rx_wr_data),
        .o_tx_rd_en(tx_rd_en), .o_tx_rd_ch(tx_rd_ch), .o_tx_rd_bitaddr(tx_rd_bitaddr),
        .i_tx_rd_data(tx_rd_data), .o_rx_off(rx_off), .o_tx_off(tx_off),
        .o_rx_thr_hit(rx_thr_hit), .o_tx_thr_hit(tx_thr_hit)
    );

    link_partner link_partner_i (
        .i_ref_clk(clk), .o_bclk(rx_bclk), .o_fs(rx_fs), .o_data(rx_data),
        .i_rd_en(tx_rd_en), .i_rd_bitaddr(tx_rd_bitaddr), .o_rd_data(tx_rd_data)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Monitor of writes, reads, receive threshold pulses and generated sync
    always @(posedge clk) begin
        cycles <= cycles + 1;
        rx_hits <= rst ? 2'h0 : (rx_hits | rx_thr_hit);
        fs_cycles <= rst ? 0 : fs_cycles + int'(tx_fs_drive);
        fs_act <= rst ? 0 : fs_act + int'(tx_fs_oe === 1'b1 && tx_fs === ~fs_active_low);
        if (rx_wr_en === 1'b1) wr_q.push_back({rx_wr_ch, rx_wr_bitaddr, rx_wr_data});
        if (tx_rd_en === 1'b1) begin
            check(ch_active[tx_rd_ch], 1'b1);
            if (tx_rd_ch != 2'h0) check(tx_rd_bitaddr, {tx_base[tx_rd_ch], 3'h0} + tx_off);
        end
        if (rst === 1'b0 && !shared_mode) check(tx_data[3:1], 3'h0);
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic run_cfg(input logic sh, sr, al, input logic [1:0] dly, ws,
            input logic [3:0] act, input logic law, input logic [UNIT_W-1:0] units,
            input logic drv, input int nf);
        int f, c, wb, wrap, o, prev, n;
        logic [3:0][15:0] w;
        logic [1:0] exp_hits;
        logic [28:0] a;
        @(posedge clk);
        rst <= 1'b1;
        shared_mode <= sh;
        sample_rise <= sr;
        fs_active_low <= al;
        fs_delay <= dly;
        word_sel <= ws;
        ch_active <= act;
        law_en <= law;
        buf_units <= units;
        tx_fs_drive <= drv;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wb = 2 << ws;
        wrap = int'(units) * (law ? 128 : 64);
        o = 0;
        n = 0;
        exp_hits = 2'h0;
        for (f = 0; f < nf; f++) begin
            for (c = 0; c < 4; c++) w[c] = 16'hC35A ^ {c[3:0], f[3:0], f[3:0], c[3:0]};
            link_partner_i.send_frame(sr, al, dly, ws, sh, w);
            repeat (20) @(posedge clk);
            check(wr_q.size(), act[0] + act[1] + act[2] + act[3]);
            for (c = 0; c < 4; c++) begin
                if (act[c] && wr_q.size() > 0) begin
                    a = {5'h00, rx_base[c]} * 8 + o;
                    check(wr_q.pop_front(), {c[1:0], a, w[c] & (16'hFFFF >> (16 - wb))});
                end
            end
            wr_q.delete();
            prev = o;
            o = (wrap == 0) ? 0 : (o + wb) % wrap;
            for (c = 0; c < 2; c++) begin
                if ((o >> 3) == int'(rx_thr[c]) && (prev >> 3) != int'(rx_thr[c])) begin
                    exp_hits[c] = 1'b1;
                end
            end
            check(rx_off, o);
            check(rx_hits, exp_hits);
            check(tx_fs_oe, drv);
        end
        if (drv) check({fs_act > 0, 2 * fs_act < fs_cycles}, 2'h3);
        tests++;
        $display("test %0d done", tests);
    endtask

    initial begin
        {cycles, miscompares, checked, fs_act, fs_cycles, tests} = '0;
        rst = 1'b1;
        {shared_mode, sample_rise, fs_active_low, law_en, tx_fs_drive} = 5'h00;
        fs_delay = 2'h0;
        word_sel = 2'h3;
        ch_active = 4'hF;
        buf_units = 21'h000100;
        rx_base = {24'h000300, 24'h000200, 24'h000100, 24'h000040};
        tx_base = {24'h000700, 24'h000600, 24'h000500, 24'h000480};
        rx_thr = {25'h0000008, 25'h0000002};
        tx_thr = {25'h0000008, 25'h0000002};
        rx_hits = 2'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Split, rising, high sync, 16 bits
        run_cfg(0, 1, 0, 2'h0, 2'h3, 4'hF, 0, 21'h000100, 0, 2);
        // Split, falling, low sync, delay 3, 4 bits, idle slots
        run_cfg(0, 0, 1, 2'h3, 2'h1, 4'hA, 0, 21'h000100, 0, 2);
        // Shared, 2 bits, driven sync
        run_cfg(1, 1, 1, 2'h1, 2'h0, 4'hF, 0, 21'h000100, 1, 2);
        // Shared, falling, delay 2, 8 bits, driven high sync
        run_cfg(1, 0, 0, 2'h2, 2'h2, 4'h7, 1, 21'h000100, 1, 3);
        // Offset wraps at 8 bytes
        run_cfg(1, 1, 0, 2'h0, 2'h3, 4'h9, 0, 21'h000001, 0, 5);
        // Offset wraps at 16 bytes with companding
        run_cfg(1, 1, 0, 2'h0, 2'h3, 4'hF, 1, 21'h000001, 0, 9);
        summarize();
    end
endmodule // tdm_serial_port_test
